// ==== shared/tods_pkg.sv ====
package tods_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  TODS_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  TODS_STAT_OFS   = 8'h04;
  localparam logic        TODS_CTRL_RST   = 1'h0;
  localparam int          TODS_CTRL_EN    = 0;
  localparam int          TODS_STAT_ACT   = 0;
  localparam int          TODS_STAT_CNT   = 16;
  localparam int          TODS_CNT_W      = 16;

  // ==========================================================================
  // Time format
  localparam int          TODS_FMT_96     = 1;
  localparam int          TODS_W96        = 96;
  localparam int          TODS_W64        = 64;
  localparam int          TODS_FRAC_W     = 16;
  localparam int          TODS_NS_W       = 48;
  localparam int          TODS_SEC_W      = 32;
  localparam logic [47:0] TODS_NS_PER_SEC = 48'h0000_3B9A_CA00;
  localparam logic [31:0] TODS_PER_DEF    = 32'h0006_6666;

  // ==========================================================================
  // Latency measurement
  localparam int          TODS_SMP_LOG2   = 6;
  localparam logic [5:0]  TODS_SMP_LAST   = 6'h3F;
  localparam int          TODS_FIFO_AW    = 3;

  // ==========================================================================
  // Slave-side sequencer
  typedef enum logic [2:0] {
    TODS_ST_IDLE = 3'b001,
    TODS_ST_RUN  = 3'b010,
    TODS_ST_LOAD = 3'b100
  } tods_state_t;

endpackage

// ==== core/tods_afifo.sv ====
`timescale 1ns/10ps

module tods_afifo #(
  parameter int W  = 96,
  parameter int AW = 3
) (
  input  wire logic          wclk,
  input  wire logic          wrst,
  input  wire logic          wen,
  input  wire logic [W-1:0]  wdata,
  output logic               wfull,
  output logic [AW:0]        wgray,
  input  wire logic          rclk,
  input  wire logic          rrst,
  input  wire logic          ren,
  output logic [W-1:0]       rdata,
  output logic               rvalid,
  output logic [AW:0]        rgray
);

  logic [W-1:0] mem [2**AW];
  logic [AW:0]  wbin_q;
  logic [AW:0]  rbin_q;
  logic [AW:0]  rg_w1_q;
  logic [AW:0]  rg_w2_q;
  logic [AW:0]  wg_r1_q;
  logic [AW:0]  wg_r2_q;
  logic         rempty;
  logic         wr_go;
  logic         rd_go;
  logic [AW:0]  wbin_d;
  logic [AW:0]  rbin_d;

  assign wr_go  = wen & ~wfull;
  assign rd_go  = ren & ~rempty;
  assign wbin_d = wbin_q + {{AW{1'b0}}, 1'b1};
  assign rbin_d = rbin_q + {{AW{1'b0}}, 1'b1};

  // ==========================================================================
  // Write side
  always_ff @(posedge wclk) begin
    if (wrst) begin
      wbin_q <= '0;
      wgray  <= '0;
    end else if (wr_go) begin
      wbin_q <= wbin_d;
      wgray  <= (wbin_d >> 1) ^ wbin_d;
    end
  end

  always_ff @(posedge wclk) begin
    if (wr_go) begin
      mem[wbin_q[AW-1:0]] <= wdata;
    end
  end

  always_ff @(posedge wclk) begin
    if (wrst) begin
      rg_w1_q <= '0;
      rg_w2_q <= '0;
    end else begin
      rg_w1_q <= rgray;
      rg_w2_q <= rg_w1_q;
    end
  end

  assign wfull = (wgray == {~rg_w2_q[AW:AW-1], rg_w2_q[AW-2:0]});

  // ==========================================================================
  // Read side
  always_ff @(posedge rclk) begin
    if (rrst) begin
      wg_r1_q <= '0;
      wg_r2_q <= '0;
    end else begin
      wg_r1_q <= wgray;
      wg_r2_q <= wg_r1_q;
    end
  end

  assign rempty = (rgray == wg_r2_q);

  always_ff @(posedge rclk) begin
    if (rrst) begin
      rbin_q <= '0;
      rgray  <= '0;
      rvalid <= 1'b0;
      rdata  <= '0;
    end else begin
      rvalid <= rd_go;
      if (rd_go) begin
        rdata  <= mem[rbin_q[AW-1:0]];
        rbin_q <= rbin_d;
        rgray  <= (rbin_d >> 1) ^ rbin_d;
      end
    end
  end

endmodule

// ==== core/tods_sync.sv ====
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps

module tods_sync
  import tods_pkg::*;
#(
  parameter int          TOD_MODE = tods_pkg::TODS_FMT_96,
  parameter logic [31:0] PER_M    = tods_pkg::TODS_PER_DEF,
  parameter logic [31:0] PER_S    = tods_pkg::TODS_PER_DEF,
  parameter int          TOD_W    = (TOD_MODE == tods_pkg::TODS_FMT_96) ?
                                    tods_pkg::TODS_W96 : tods_pkg::TODS_W64
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic             clk_master,
  input  wire logic             rst_master,
  input  wire logic [TOD_W-1:0] tod_master_data,
  input  wire logic             clk_slave,
  input  wire logic             rst_slave,
  input  wire logic             start_tod_sync,
  output logic                  tod_slave_valid,
  output logic [TOD_W-1:0]      tod_slave_data,
  input  wire logic             clk_sampling
);
  import tods_pkg::*;

  localparam int AW  = TODS_FIFO_AW;
  localparam int SW  = AW + 1 + TODS_SMP_LOG2;
  localparam int PW  = SW + 32;

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ==========================================================================
  // AHB-Lite register slave
  logic                  wr_pend_q;
  logic [7:0]            waddr_q;
  logic                  ctrl_en_q;
  logic [TODS_CNT_W-1:0] sync_cnt_q;
  logic                  act_h1_q;
  logic                  act_h2_q;
  logic                  vt_h1_q;
  logic                  vt_h2_q;
  logic                  vt_h3_q;
  logic                  addr_ok;
  logic                  act_s;
  logic                  vtgl_s_q;

  assign addr_ok = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      waddr_q   <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok) begin
        waddr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_q <= TODS_CTRL_RST;
    end else if (wr_pend_q && waddr_q == TODS_CTRL_OFS) begin
      ctrl_en_q <= hwdata[TODS_CTRL_EN];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= '0;
      if (haddr[7:0] == TODS_CTRL_OFS) begin
        hrdata[TODS_CTRL_EN] <= ctrl_en_q;
      end else if (haddr[7:0] == TODS_STAT_OFS) begin
        hrdata[TODS_STAT_ACT] <= act_h2_q;
        hrdata[TODS_STAT_CNT +: TODS_CNT_W] <= sync_cnt_q;
      end
    end
  end

  // Slave activity level and delivery toggle brought into the bus domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_h1_q   <= 1'b0;
      act_h2_q   <= 1'b0;
      vt_h1_q    <= 1'b0;
      vt_h2_q    <= 1'b0;
      vt_h3_q    <= 1'b0;
      sync_cnt_q <= '0;
    end else begin
      act_h1_q <= act_s;
      act_h2_q <= act_h1_q;
      vt_h1_q  <= vtgl_s_q;
      vt_h2_q  <= vt_h1_q;
      vt_h3_q  <= vt_h2_q;
      if (vt_h2_q != vt_h3_q) begin
        sync_cnt_q <= sync_cnt_q + {{(TODS_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================================
  // Slave-side request
  logic en_s1_q;
  logic en_s2_q;

  always_ff @(posedge clk_slave) begin
    if (rst_slave) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else begin
      en_s1_q <= ctrl_en_q;
      en_s2_q <= en_s1_q;
    end
  end

  assign act_s = ~rst_slave & (start_tod_sync | en_s2_q);

  // ==========================================================================
  // Master domain and crossing FIFO
  logic            act_m1_q;
  logic            act_m2_q;
  logic            wfull;
  logic [AW:0]     wgray;
  logic [AW:0]     rgray;
  logic [TOD_W-1:0] fifo_q;
  logic            fifo_vld;

  always_ff @(posedge clk_master) begin
    if (rst_master) begin
      act_m1_q <= 1'b0;
      act_m2_q <= 1'b0;
    end else begin
      act_m1_q <= act_s;
      act_m2_q <= act_m1_q;
    end
  end

  // Slave reads constantly so the FIFO stays shallow and its depth is the delay
  tods_afifo #(
    .W  (TOD_W),
    .AW (AW)
  ) u_fifo (
    .wclk   (clk_master),
    .wrst   (rst_master),
    .wen    (act_m2_q & ~wfull),
    .wdata  (tod_master_data),
    .wfull  (wfull),
    .wgray  (wgray),
    .rclk   (clk_slave),
    .rrst   (rst_slave),
    .ren    (1'b1),
    .rdata  (fifo_q),
    .rvalid (fifo_vld),
    .rgray  (rgray)
  );

  // ==========================================================================
  // Sampling domain: fill level averaged over a window
  logic        srst1_q;
  logic        srst2_q;
  logic [AW:0] wg_p1_q;
  logic [AW:0] wg_p2_q;
  logic [AW:0] rg_p1_q;
  logic [AW:0] rg_p2_q;
  logic [5:0]  smp_cnt_q;
  logic [SW-1:0] sum_q;
  logic [SW-1:0] sum_fin;
  logic [PW-1:0] prod;
  logic [AW:0] fill;
  logic [63:0] lat_p_q;
  logic        ltgl_p_q;

  always_ff @(posedge clk_sampling or posedge rst_slave) begin
    if (rst_slave) begin
      srst1_q <= 1'b1;
      srst2_q <= 1'b1;
    end else begin
      srst1_q <= 1'b0;
      srst2_q <= srst1_q;
    end
  end

  always_ff @(posedge clk_sampling) begin
    wg_p1_q <= wgray;
    wg_p2_q <= wg_p1_q;
    rg_p1_q <= rgray;
    rg_p2_q <= rg_p1_q;
  end

  assign fill    = gray2bin(wg_p2_q) - gray2bin(rg_p2_q);
  assign sum_fin = sum_q + SW'(fill);
  assign prod    = PW'(sum_fin) * PW'(PER_M);

  always_ff @(posedge clk_sampling) begin
    if (srst2_q) begin
      smp_cnt_q <= '0;
      sum_q     <= '0;
      lat_p_q   <= '0;
      ltgl_p_q  <= 1'b0;
    end else begin
      smp_cnt_q <= smp_cnt_q + 6'h01;
      if (smp_cnt_q == TODS_SMP_LAST) begin
        sum_q    <= '0;
        lat_p_q  <= 64'(prod >> TODS_SMP_LOG2);
        ltgl_p_q <= ~ltgl_p_q;
      end else begin
        sum_q <= sum_fin;
      end
    end
  end

  // ==========================================================================
  // Slave domain: latency pickup, correction and delivery
  tods_state_t st_q;
  logic        lt_s1_q;
  logic        lt_s2_q;
  logic        lt_s3_q;
  logic [63:0] lat_s_q;
  logic [95:0] d96;
  logic [63:0] low;
  logic [95:0] res;

  always_ff @(posedge clk_slave) begin
    if (rst_slave) begin
      lt_s1_q <= 1'b0;
      lt_s2_q <= 1'b0;
      lt_s3_q <= 1'b0;
      lat_s_q <= '0;
    end else begin
      lt_s1_q <= ltgl_p_q;
      lt_s2_q <= lt_s1_q;
      lt_s3_q <= lt_s2_q;
      if (lt_s2_q != lt_s3_q) begin
        lat_s_q <= lat_p_q;
      end
    end
  end

  always_comb begin
    d96 = 96'(fifo_q);
    low = d96[63:0] + lat_s_q + 64'(PER_S);
    res = {d96[95:64], low};
    if (TOD_MODE == TODS_FMT_96 &&
        low[TODS_FRAC_W +: TODS_NS_W] >= TODS_NS_PER_SEC) begin
      res[TODS_FRAC_W +: TODS_NS_W] = low[TODS_FRAC_W +: TODS_NS_W] - TODS_NS_PER_SEC;
      res[TODS_W64 +: TODS_SEC_W]   = d96[TODS_W64 +: TODS_SEC_W] + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_slave) begin
    if (rst_slave) begin
      st_q            <= TODS_ST_IDLE;
      tod_slave_valid <= 1'b0;
      tod_slave_data  <= '0;
      vtgl_s_q        <= 1'b0;
    end else begin
      tod_slave_valid <= 1'b0;
      case (st_q)
        TODS_ST_IDLE: begin
          if (act_s) begin
            st_q <= TODS_ST_RUN;
          end
        end
        TODS_ST_RUN: begin
          if (!act_s) begin
            st_q <= TODS_ST_IDLE;
          end else if (lt_s2_q != lt_s3_q) begin
            st_q <= TODS_ST_LOAD;
          end
        end
        TODS_ST_LOAD: begin
          if (!act_s) begin
            st_q <= TODS_ST_IDLE;
          end else if (fifo_vld) begin
            // Data holds until the next delivery so the load a cycle later sees it
            tod_slave_data  <= res[TOD_W-1:0];
            tod_slave_valid <= 1'b1;
            vtgl_s_q        <= ~vtgl_s_q;
            st_q            <= TODS_ST_RUN;
          end
        end
        default: begin
          st_q <= TODS_ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== tb/tods_sync_assertions.sv ====
`timescale 1ns/10ps

module tods_sync_assertions #(
  parameter int TOD_W = 64
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic             clk_slave,
  input wire logic             rst_slave,
  input wire logic             tod_slave_valid,
  input wire logic [TOD_W-1:0] tod_slave_data
);
  // ==========================================================================
  // Slave time output
  sequence s_pulse;
    tod_slave_valid ##1 !tod_slave_valid;
  endsequence

  a_valid_pulse: assert property (@(posedge clk_slave) disable iff (rst_slave)
    $rose(tod_slave_valid) |-> s_pulse) else $error("valid wider than one cycle");
  a_valid_gap: assert property (@(posedge clk_slave) disable iff (rst_slave)
    tod_slave_valid |=> !tod_slave_valid [*8]) else $error("values arrive too close");
  a_data_holds: assert property (@(posedge clk_slave) disable iff (rst_slave)
    !tod_slave_valid |-> $stable(tod_slave_data)) else $error("data moved without valid");
  a_value_rises: assert property (@(posedge clk_slave) disable iff (rst_slave)
    tod_slave_valid |-> tod_slave_data > $past(tod_slave_data)) else $error("time went back");
  a_rst_clears: assert property (@(posedge clk_slave) disable iff (rst_slave)
    $fell(rst_slave) |-> !tod_slave_valid && tod_slave_data == '0)
    else $error("slave outputs not cleared");
  a_rst_drops: assert property (@(posedge clk_slave) disable iff (rst_slave)
    $fell(rst_slave) |-> !tod_slave_valid [*3]) else $error("transfer survived reset");

  // ==========================================================================
  // Register bus
  a_bus_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout) else $error("wait state inserted");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    !hresp) else $error("response not okay");
endmodule

bind tods_sync tods_sync_assertions #(.TOD_W(TOD_W)) u_chk (
  .hclk, .hresetn, .hreadyout, .hresp, .clk_slave, .rst_slave,
  .tod_slave_valid, .tod_slave_data);

// ==== tb/tods_tod_model.sv ====
`timescale 1ns/10ps

module tods_tod_model #(
  parameter int          TOD_W = 64,
  parameter logic [31:0] PER   = 32'h0006_6666
) (
  input  wire logic             clk_master,
  input  wire logic             rst_master,
  input  wire logic [TOD_W-1:0] init_val,
  output logic      [TOD_W-1:0] tod_master_data,
  input  wire logic             clk_slave,
  input  wire logic             tod_slave_valid,
  input  wire logic [TOD_W-1:0] tod_slave_data,
  output logic      [TOD_W-1:0] slave_tod
);
  // ==========================================================================
  // Master counter, plain 48.16 add
  always_ff @(posedge clk_master) begin
    if (rst_master) begin
      tod_master_data <= init_val;
    end else begin
      tod_master_data <= tod_master_data + TOD_W'(PER);
    end
  end

  // ==========================================================================
  // Slave counter loads in the cycle after valid
  always_ff @(posedge clk_slave) begin
    if (tod_slave_valid) begin
      slave_tod <= tod_slave_data;
    end else begin
      slave_tod <= slave_tod + TOD_W'(PER);
    end
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps

module tb_top;
  import tods_pkg::*;
  localparam int          W   = TODS_W64;
  localparam logic [63:0] TOL = 64'h0000_0000_0030_0000;
  logic          hclk = 0, clk_master = 0, clk_slave = 0, clk_sampling = 0;
  logic          hresetn = 0, rst_master = 1, rst_slave = 1, start_tod_sync = 0;
  logic          hsel = 0, hwrite = 0, hreadyout, hresp, tod_slave_valid, vq = 0, rd_q = 0;
  logic [1:0]    htrans = '0;
  logic [31:0]   haddr = '0, hwdata = '0, hrdata;
  logic [W-1:0]  tod_master_data, tod_slave_data, slave_tod, init_val = 64'h1, d;
  logic [63:0]   rdq[$];
  logic [63:0]   e;
  int            mismatches = 0, n_checks = 0, n_valid = 0, cyc = 0;

  initial forever #20 hclk = ~hclk;
  initial forever #3.2 clk_master = ~clk_master;
  initial begin #1.1; forever #3.2 clk_slave = ~clk_slave; end
  initial forever #3.15 clk_sampling = ~clk_sampling;

  tods_sync #(.TOD_MODE(0)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .clk_master,
    .rst_master, .tod_master_data, .clk_slave, .rst_slave, .start_tod_sync,
    .tod_slave_valid, .tod_slave_data, .clk_sampling);
  tods_tod_model #(.TOD_W(W)) u_model (.clk_master, .rst_master, .init_val,
    .tod_master_data, .clk_slave, .tod_slave_valid, .tod_slave_data, .slave_tod);

  // ==========================================================================
  // Checks and closing
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    n_checks++;
    if (ex !== got) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (rd_q && hreadyout === 1'b1) begin
      e = rdq.pop_front();
      chk("hrdata", {32'h0, e[31:0]}, {32'h0, hrdata & e[63:32]});
    end
    if (hreadyout === 1'b1) rd_q <= hsel && htrans[1] && !hwrite;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test;
    end
  end

  // Loaded slave time must track the master closely
  always @(posedge clk_slave) begin
    vq <= tod_slave_valid;
    if (tod_slave_valid === 1'b1) n_valid++;
    if (vq === 1'b1) begin
      d = slave_tod - tod_master_data;
      chk("slave time near master", 1, (d < TOL) || (-d < TOL));
    end
  end

  // ==========================================================================
  // Drivers
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] dv,
                     input logic [31:0] m);
    if (!w) rdq.push_back({m, dv});
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? dv : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wait_vals(input int n);
    int s;
    s = n_valid;
    repeat (3000) begin
      @(posedge clk_slave);
      #1;
      if (n_valid >= s + n) break;
    end
    chk("values delivered", 1, n_valid >= s + n);
  endtask

  task automatic idle_check;
    int s;
    repeat (300) @(posedge clk_slave);
    s = n_valid;
    repeat (300) @(posedge clk_slave);
    chk("no values while stopped", s, n_valid);
  endtask

  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(32'h496D0E38));
    init_val = {8'h0, $urandom, 24'h1};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge clk_master) rst_master <= 1'b0;
    @(posedge clk_slave) rst_slave <= 1'b0;
    @(posedge clk_slave) start_tod_sync <= 1'b1;
    wait_vals(4);
    @(posedge clk_slave) start_tod_sync <= 1'b0;
    idle_check();
    $display("test request pin done");
    @(posedge hclk);
    ahb(TODS_CTRL_OFS, 1'b1, 32'h1, 32'h0);
    ahb(TODS_CTRL_OFS, 1'b0, 32'h1, 32'hFFFF_FFFF);
    ahb(8'h08, 1'b0, 32'h0, 32'hFFFF_FFFF);
    wait_vals(3);
    @(posedge hclk);
    ahb(TODS_STAT_OFS, 1'b0, 32'h1, 32'h1);
    ahb(TODS_CTRL_OFS, 1'b1, 32'h0, 32'h0);
    idle_check();
    @(posedge hclk);
    ahb(TODS_STAT_OFS, 1'b0, {n_valid[15:0], 16'h0}, 32'hFFFF_FFFF);
    $display("test register enable done");
    @(posedge clk_slave) start_tod_sync <= 1'b1;
    wait_vals(1);
    // Reset lands well before the next delivery so no stale time is loaded
    repeat ($urandom_range(40, 5)) @(posedge clk_slave);
    @(posedge clk_master) rst_master <= 1'b1;
    @(posedge clk_slave) rst_slave <= 1'b1;
    repeat (5) @(posedge clk_slave);
    @(posedge clk_master) rst_master <= 1'b0;
    @(posedge clk_slave) rst_slave <= 1'b0;
    wait_vals(2);
    $display("test reset mid transfer done");
    end_of_test;
  end
endmodule
